// ---- rtl/rcs_pkg.sv ----
// package for the reset and clock switch controller: register map,
// field positions, reset values, timing counts and the mode type.
// assumes a 20 MHz aclk and a 16 MHz fast oscillator for the timings.
package rcs_pkg;
   // clock and timing
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned FC_KHZ = 16000;
   localparam int unsigned MALF_FC_PERIODS = 24;
   localparam int unsigned EXT_FC_PERIODS = 12;
   localparam int unsigned MALF_MAX_NS = MALF_FC_PERIODS * 1000000 / FC_KHZ;
   localparam int unsigned EXT_MIN_NS = EXT_FC_PERIODS * 1000000 / FC_KHZ;
   // longest time rounds down, least time rounds up
   localparam int unsigned MALF_CYCLES = MALF_MAX_NS / CLK_PERIOD_NS;
   localparam int unsigned EXT_MIN_CYCLES =
      (EXT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W = 8;

   // register byte offsets
   localparam logic [7:0] OFF_SYSCTL = 8'h00;
   localparam logic [7:0] OFF_TRAPCFG = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_MASK = 8'h0c;
   localparam logic [7:0] OFF_MODE = 8'h10;

   // system_control_two fields
   localparam int unsigned SC_SYSCK = 5;
   localparam int unsigned SC_XTEN = 6;
   localparam int unsigned SC_XEN = 7;
   localparam logic RST_SYSCK = 1'b0;
   localparam logic RST_XTEN = 1'b0;
   localparam logic RST_XEN = 1'b1;

   // trap configuration fields
   localparam int unsigned TC_RAM_SEL = 0;
   localparam int unsigned TC_TO_RESET = 1;
   localparam int unsigned TC_DBR_EN = 2;
   localparam int unsigned TC_SFR_EN = 3;
   localparam logic [3:0] RST_TRAPCFG = 4'hf;

   // status / mask bits
   localparam int unsigned NUM_EV = 6;
   localparam int unsigned EV_EXT = 0;
   localparam int unsigned EV_TRAP_RST = 1;
   localparam int unsigned EV_WDT = 2;
   localparam int unsigned EV_CLK = 3;
   localparam int unsigned EV_TRAP_IRQ = 4;
   localparam int unsigned EV_SWITCH = 5;

   // trap address areas
   localparam logic [15:0] SFR_LO = 16'h0000;
   localparam logic [15:0] SFR_HI = 16'h003f;
   localparam logic [15:0] RAM_LO = 16'h0040;
   localparam logic [15:0] RAM_HI = 16'h023f;
   localparam logic [15:0] DBR_LO = 16'h0f80;
   localparam logic [15:0] DBR_HI = 16'h0fff;
   localparam logic [15:0] RESET_VECTOR = 16'hfffe;

   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      MODE_FAST_ONLY,
      MODE_FAST_DUAL,
      MODE_SLOW_DUAL,
      MODE_SLOW_ONLY
   } rcs_mode_t;
endpackage

// ---- rtl/rcs_sync.sv ----
// two-flop synchroniser for levels that come from outside aclk.
// assumes each bit is an independent level; no bus coherence.
`timescale 1ns/1ns
module rcs_sync #(
   parameter int unsigned WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;

   // first flop feeds only the second
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_reg <= INIT;
         sync_out <= INIT;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule

// ---- rtl/rcs_ctrl.sv ----
// reset generator and main clock switch control, axi4-lite slave.
// assumes fetch and watchdog inputs come from logic on aclk; the reset
// pin and the slow clock arrive asynchronously.
// Behaviour
// - four reset sources; trap, watchdog and clock faults give a reset of at most 24 fast periods.
// - malfunction reset has no power-on init, so a pulse of up to 24 fast periods may follow power-up; here the counter loads at power-up, so it always does.
// - the reset pin must stay low at least 12 fast periods before a reset is recognised.
// - when the pin returns high, reset ends and the reset vector at the top word is fetched.
// - reset clears master and individual interrupt enables and interrupt latches.
// - reset clears the prescaler and divider and leaves the watchdog enabled.
// - a fetch from the data bank, special register area, or ram when its select is set, traps.
// - trap response (reset or interrupt) and trapped areas are selectable.
// - clearing both oscillator enables, or the one that feeds the current clock, raises a clock reset; here sysck_reg, not main_clock_slow, picks that one.
// - on a clock reset the oscillators keep running; here the reset keeps the fast one but clears the slow osc enable; reset lasts at most 24 fast periods.
// - system_control_two bit 5 is clock select, bit 6 slow osc enable, bit 7 fast osc enable.
// - after the select is cleared the slow clock stays in use until the clocks are in step.
// - a low reset pin ends slow operation; after reset fast_clock_only_operation is entered.
`timescale 1ns/1ns
module rcs_ctrl #(
   parameter int unsigned ADDR_W = 8
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data and response
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // pins
   input wire logic reset_pin_n,
   input wire logic low_frequency_clock,
   // core side
   input wire logic fetch_valid,
   input wire logic [15:0] fetch_addr,
   input wire logic wdt_reset_req,
   // reset, clock and interrupt outputs
   output logic sys_reset_n,
   output logic vector_fetch,
   output logic irq_state_clear,
   output logic timing_clear,
   output logic wdt_enable_force,
   output logic hf_osc_enable,
   output logic lf_osc_enable,
   output logic main_clock_slow,
   output logic trap_irq,
   output logic irq
);
   if (ADDR_W < 5) begin : g_chk
      $error("rcs_ctrl: ADDR_W too small for the register map");
   end

   logic pin_n_s, tick_s, tick_d_reg;
   logic [rcs_pkg::CNT_W-1:0] ext_cnt_reg, malf_cnt_reg;
   logic ext_active_reg, malf_req_reg, in_reset, ext_ev;
   logic xen_reg, xten_reg, sysck_reg;
   logic [3:0] trapcfg_reg;
   logic [rcs_pkg::NUM_EV-1:0] status_reg, mask_reg, events;
   logic trap_hit, trap_rst_req, clk_fault, switch_ev, tick_rise;
   logic aw_got, w_got, do_write, wr_ok;
   logic [ADDR_W-1:0] awaddr_reg;
   logic [31:0] wdata_reg, rd_data;
   logic [3:0] wstrb_reg;
   logic rd_ok;
   rcs_pkg::rcs_mode_t mode;

   localparam logic [rcs_pkg::CNT_W-1:0] EXT_MIN =
      rcs_pkg::CNT_W'(rcs_pkg::EXT_MIN_CYCLES);
   localparam logic [rcs_pkg::CNT_W-1:0] MALF_LOAD =
      rcs_pkg::CNT_W'(rcs_pkg::MALF_CYCLES);

   // pin and slow clock resynchronised
   rcs_sync #(.WIDTH(2), .INIT(2'b10)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in({reset_pin_n, low_frequency_clock}),
      .sync_out({pin_n_s, tick_s})
   );

   // external pin low-time filter
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_cnt_reg <= '0;
         ext_active_reg <= 1'b0;
      end else if (pin_n_s) begin
         ext_cnt_reg <= '0;
         ext_active_reg <= 1'b0;
      end else begin
         if (ext_cnt_reg != EXT_MIN)
            ext_cnt_reg <= ext_cnt_reg + 1'b1;
         if (ext_cnt_reg == EXT_MIN - 1'b1)
            ext_active_reg <= 1'b1;
      end
   end
   assign ext_ev = !pin_n_s && !ext_active_reg &&
      (ext_cnt_reg == EXT_MIN - 1'b1);

   // malfunction requests gathered into one registered request
   always_ff @(posedge aclk) begin
      if (!aresetn)
         malf_req_reg <= 1'b0;
      else
         malf_req_reg <= trap_rst_req | wdt_reset_req | clk_fault;
   end

   // malfunction reset length; starts loaded after power-up
   always_ff @(posedge aclk) begin
      if (!aresetn)
         malf_cnt_reg <= MALF_LOAD;
      else if (malf_req_reg)
         malf_cnt_reg <= MALF_LOAD;
      else if (malf_cnt_reg != '0)
         malf_cnt_reg <= malf_cnt_reg - 1'b1;
   end
   assign in_reset = ext_active_reg || (malf_cnt_reg != '0);

   // internal reset and vector fetch, released on aclk
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sys_reset_n <= 1'b0;
         vector_fetch <= 1'b0;
      end else begin
         sys_reset_n <= !in_reset;
         vector_fetch <= !sys_reset_n && !in_reset;
      end
   end

   // state cleared while reset is applied
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_state_clear <= 1'b1;
         timing_clear <= 1'b1;
         wdt_enable_force <= 1'b1;
      end else begin
         irq_state_clear <= in_reset;
         timing_clear <= in_reset;
         wdt_enable_force <= in_reset;
      end
   end

   // address trap detection
   always_comb begin
      trap_hit = 1'b0;
      if (fetch_valid && sys_reset_n) begin
         if (trapcfg_reg[rcs_pkg::TC_SFR_EN] && fetch_addr >= rcs_pkg::SFR_LO
             && fetch_addr <= rcs_pkg::SFR_HI)
            trap_hit = 1'b1;
         if (trapcfg_reg[rcs_pkg::TC_RAM_SEL] &&
             fetch_addr >= rcs_pkg::RAM_LO && fetch_addr <= rcs_pkg::RAM_HI)
            trap_hit = 1'b1;
         if (trapcfg_reg[rcs_pkg::TC_DBR_EN] && fetch_addr >= rcs_pkg::DBR_LO
             && fetch_addr <= rcs_pkg::DBR_HI)
            trap_hit = 1'b1;
      end
   end
   assign trap_rst_req = trap_hit && trapcfg_reg[rcs_pkg::TC_TO_RESET];

   // trap interrupt pulse
   always_ff @(posedge aclk) begin
      if (!aresetn)
         trap_irq <= 1'b0;
      else
         trap_irq <= trap_hit && !trapcfg_reg[rcs_pkg::TC_TO_RESET];
   end

   // axi write channel handshakes
   assign aw_got = !s_axi_awready;
   assign w_got = !s_axi_wready;
   assign do_write = aw_got && w_got && !s_axi_bvalid;
   assign wr_ok = (awaddr_reg == ADDR_W'(rcs_pkg::OFF_SYSCTL)) ||
      (awaddr_reg == ADDR_W'(rcs_pkg::OFF_TRAPCFG)) ||
      (awaddr_reg == ADDR_W'(rcs_pkg::OFF_STATUS)) ||
      (awaddr_reg == ADDR_W'(rcs_pkg::OFF_MASK)) ||
      (awaddr_reg == ADDR_W'(rcs_pkg::OFF_MODE));

   // write address, data and response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= rcs_pkg::RESP_OKAY;
         awaddr_reg <= '0;
         wdata_reg <= '0;
         wstrb_reg <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            awaddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? rcs_pkg::RESP_OKAY : rcs_pkg::RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // clock reset check on a write to system_control_two
   always_comb begin
      clk_fault = 1'b0;
      if (do_write && wstrb_reg[0] &&
          awaddr_reg == ADDR_W'(rcs_pkg::OFF_SYSCTL)) begin
         if (!wdata_reg[rcs_pkg::SC_XEN] && !wdata_reg[rcs_pkg::SC_XTEN])
            clk_fault = 1'b1;
         if (xen_reg && !wdata_reg[rcs_pkg::SC_XEN] && !sysck_reg)
            clk_fault = 1'b1;
         if (xten_reg && !wdata_reg[rcs_pkg::SC_XTEN] && sysck_reg)
            clk_fault = 1'b1;
      end
   end

   // system_control_two; a faulty write is dropped, then the reset keeps the fast osc on and clears the slow osc enable
   always_ff @(posedge aclk) begin
      if (!aresetn || in_reset) begin
         xen_reg <= rcs_pkg::RST_XEN;
         xten_reg <= rcs_pkg::RST_XTEN;
         sysck_reg <= rcs_pkg::RST_SYSCK;
      end else if (do_write && wstrb_reg[0] && !clk_fault &&
                   awaddr_reg == ADDR_W'(rcs_pkg::OFF_SYSCTL)) begin
         xen_reg <= wdata_reg[rcs_pkg::SC_XEN];
         xten_reg <= wdata_reg[rcs_pkg::SC_XTEN];
         sysck_reg <= wdata_reg[rcs_pkg::SC_SYSCK];
      end
   end

   // oscillator enables to the pads
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hf_osc_enable <= rcs_pkg::RST_XEN;
         lf_osc_enable <= rcs_pkg::RST_XTEN;
      end else begin
         hf_osc_enable <= xen_reg;
         lf_osc_enable <= xten_reg;
      end
   end

   // trap configuration
   always_ff @(posedge aclk) begin
      if (!aresetn || in_reset)
         trapcfg_reg <= rcs_pkg::RST_TRAPCFG;
      else if (do_write && wstrb_reg[0] &&
               awaddr_reg == ADDR_W'(rcs_pkg::OFF_TRAPCFG))
         trapcfg_reg <= wdata_reg[3:0];
   end

   // clock changeover on a slow clock edge
   assign tick_rise = tick_s && !tick_d_reg;
   assign switch_ev = tick_rise && (sysck_reg != main_clock_slow);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_d_reg <= 1'b0;
         main_clock_slow <= 1'b0;
      end else begin
         tick_d_reg <= tick_s;
         if (in_reset)
            main_clock_slow <= 1'b0;
         else if (switch_ev)
            main_clock_slow <= sysck_reg;
      end
   end

   // operating mode for readback
   always_comb begin
      case ({main_clock_slow, xen_reg, xten_reg})
         3'b010: mode = rcs_pkg::MODE_FAST_ONLY;
         3'b011: mode = rcs_pkg::MODE_FAST_DUAL;
         3'b111: mode = rcs_pkg::MODE_SLOW_DUAL;
         3'b101: mode = rcs_pkg::MODE_SLOW_ONLY;
         default: mode = rcs_pkg::MODE_FAST_DUAL;
      endcase
   end

   // sticky events, write one to clear, set wins
   always_comb begin
      events = '0;
      events[rcs_pkg::EV_EXT] = ext_ev;
      events[rcs_pkg::EV_TRAP_RST] = trap_rst_req;
      events[rcs_pkg::EV_WDT] = wdt_reset_req;
      events[rcs_pkg::EV_CLK] = clk_fault;
      events[rcs_pkg::EV_TRAP_IRQ] = trap_hit &&
         !trapcfg_reg[rcs_pkg::TC_TO_RESET];
      events[rcs_pkg::EV_SWITCH] = switch_ev;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn)
         status_reg <= '0;
      else if (do_write && wstrb_reg[0] &&
               awaddr_reg == ADDR_W'(rcs_pkg::OFF_STATUS))
         status_reg <= (status_reg &
            ~wdata_reg[rcs_pkg::NUM_EV-1:0]) | events;
      else
         status_reg <= status_reg | events;
   end

   // interrupt mask and output
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_reg <= '0;
         irq <= 1'b0;
      end else begin
         if (do_write && wstrb_reg[0] &&
             awaddr_reg == ADDR_W'(rcs_pkg::OFF_MASK))
            mask_reg <= wdata_reg[rcs_pkg::NUM_EV-1:0];
         irq <= |(status_reg & mask_reg);
      end
   end

   // read decode
   always_comb begin
      rd_data = '0;
      rd_ok = 1'b1;
      case (s_axi_araddr)
         ADDR_W'(rcs_pkg::OFF_SYSCTL): begin
            rd_data[rcs_pkg::SC_XEN] = xen_reg;
            rd_data[rcs_pkg::SC_XTEN] = xten_reg;
            rd_data[rcs_pkg::SC_SYSCK] = sysck_reg;
         end
         ADDR_W'(rcs_pkg::OFF_TRAPCFG): rd_data[3:0] = trapcfg_reg;
         ADDR_W'(rcs_pkg::OFF_STATUS):
            rd_data[rcs_pkg::NUM_EV-1:0] = status_reg;
         ADDR_W'(rcs_pkg::OFF_MASK): rd_data[rcs_pkg::NUM_EV-1:0] = mask_reg;
         ADDR_W'(rcs_pkg::OFF_MODE): begin
            rd_data[1:0] = mode;
            rd_data[2] = sysck_reg != main_clock_slow;
         end
         default: rd_ok = 1'b0;
      endcase
   end

   // read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= rcs_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_data;
         s_axi_rresp <= rd_ok ? rcs_pkg::RESP_OKAY : rcs_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
endmodule

// ---- verification/rcs_ctrl_assertions.sv ----
// checker for rcs_ctrl: internal reset and clock switch relations.
// assumes it is bound to rcs_ctrl and sees only that module's ports.
`timescale 1ns/1ns
module rcs_chk (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // reset requests
   input wire logic reset_pin_n,
   input wire logic fetch_valid,
   input wire logic wdt_reset_req,
   // reset, clock and interrupt outputs
   input wire logic sys_reset_n,
   input wire logic vector_fetch,
   input wire logic irq_state_clear,
   input wire logic timing_clear,
   input wire logic wdt_enable_force,
   input wire logic hf_osc_enable,
   input wire logic lf_osc_enable,
   input wire logic main_clock_slow,
   input wire logic trap_irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [7:0] low_cnt;
   logic [7:0] pin_cnt;

   // cycles of internal reset since the last request
   always_ff @(posedge aclk) begin
      if (!aresetn || sys_reset_n || !reset_pin_n || wdt_reset_req ||
          fetch_valid) begin
         low_cnt <= 8'h00;
      end else if (low_cnt != 8'hff) begin
         low_cnt <= low_cnt + 8'h01;
      end
   end

   // cycles the reset pin has been held low
   always_ff @(posedge aclk) begin
      if (!aresetn || reset_pin_n) begin
         pin_cnt <= 8'h00;
      end else if (pin_cnt != 8'hff) begin
         pin_cnt <= pin_cnt + 8'h01;
      end
   end

   wdt_reset_a: assert property (
      wdt_reset_req && sys_reset_n |-> ##[1:3] !sys_reset_n)
      else $error("watchdog request gave no reset");
   malf_len_a: assert property (low_cnt <= 8'h22)
      else $error("internal reset too long");
   pin_reset_a: assert property (pin_cnt >= 8'h18 |-> !sys_reset_n)
      else $error("long pin low gave no reset");
   pin_release_a: assert property (
      pin_cnt >= 8'h18 && reset_pin_n |-> ##[1:8] sys_reset_n)
      else $error("reset not released after pin");
   reset_clears_a: assert property (!sys_reset_n |->
      irq_state_clear && timing_clear && wdt_enable_force)
      else $error("clear outputs low in reset");
   vector_rise_a: assert property ($rose(sys_reset_n) |-> vector_fetch)
      else $error("no vector fetch at release");
   vector_once_a: assert property (
      vector_fetch |-> sys_reset_n ##1 !vector_fetch)
      else $error("vector fetch not a single pulse");
   start_fast_a: assert property ($rose(sys_reset_n) |->
      !main_clock_slow && hf_osc_enable && !lf_osc_enable)
      else $error("not fast clock only after reset");
   osc_alive_a: assert property (
      sys_reset_n |-> hf_osc_enable || lf_osc_enable)
      else $error("both oscillators stopped");

   // main scenarios
   cover property ($rose(sys_reset_n));
   cover property (trap_irq);
   cover property ($rose(main_clock_slow));
   cover property (pin_cnt == 8'h18);
endmodule

bind rcs_ctrl rcs_chk u_chk (
   .aclk(aclk),
   .aresetn(aresetn),
   .reset_pin_n(reset_pin_n),
   .fetch_valid(fetch_valid),
   .wdt_reset_req(wdt_reset_req),
   .sys_reset_n(sys_reset_n),
   .vector_fetch(vector_fetch),
   .irq_state_clear(irq_state_clear),
   .timing_clear(timing_clear),
   .wdt_enable_force(wdt_enable_force),
   .hf_osc_enable(hf_osc_enable),
   .lf_osc_enable(lf_osc_enable),
   .main_clock_slow(main_clock_slow),
   .trap_irq(trap_irq)
);

// ---- verification/rcs_ctrl_test.sv ----
// self-checking bench for rcs_ctrl: registers, clock switch, resets.
// assumes the axi4-lite slave timing and register map of the rcs_pkg.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
   num_errors++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module rcs_ctrl_test;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic reset_pin_n = 1'b1;
   logic low_frequency_clock = 1'b0;
   logic fetch_valid = 1'b0;
   logic [15:0] fetch_addr = 16'h0;
   logic wdt_reset_req = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, sys_reset_n, vector_fetch, hf_osc_enable;
   logic lf_osc_enable, main_clock_slow, trap_irq, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [31:0] su [3] = '{32'h80, 32'hc0, 32'he0};
   logic [31:0] fv [3] = '{32'h00, 32'h40, 32'ha0};
   logic [15:0] ta [3] = '{16'h0010, 16'h0100, 16'h0f90};
   int num_errors = 0;
   int n_checks = 0;
   int trap_cnt = 0;

   rcs_ctrl DUT (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .reset_pin_n, .low_frequency_clock, .fetch_valid, .fetch_addr,
      .wdt_reset_req, .sys_reset_n, .vector_fetch, .irq_state_clear(),
      .timing_clear(), .wdt_enable_force(), .hf_osc_enable,
      .lf_osc_enable, .main_clock_slow, .trap_irq, .irq
   );

   // 20 mhz clock
   always #25 aclk = ~aclk;

   // counts interrupt-mode trap pulses
   always @(posedge aclk) begin
      if (trap_irq === 1'b1) trap_cnt <= trap_cnt + 1;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // axi4-lite write, address and data offered together
   task automatic axw(input logic [7:0] a, input logic [31:0] dd,
                      output logic [1:0] r);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= dd;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 64);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   // axi4-lite read
   task automatic axr(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 64);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] dd);
      logic [1:0] r;
      axw(a, dd, r);
      `CHK("write resp", rcs_pkg::RESP_OKAY, r)
      cyc(2);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      axr(a, d, r);
      `CHK("read data", e, d)
      `CHK("read resp", rcs_pkg::RESP_OKAY, r)
   endtask

   task automatic stat(input int b, input logic e);
      logic [31:0] d;
      logic [1:0] r;
      axr(rcs_pkg::OFF_STATUS, d, r);
      `CHK("status bit", e, d[b])
   endtask

   // waits for internal reset release, then checks the vector fetch pulse
   task automatic relwait(output int n);
      n = 0;
      while (sys_reset_n !== 1'b1 && n < 100) begin
         @(posedge aclk);
         #1;
         n++;
      end
      `CHK("vector fetch", 1'b1, vector_fetch)
   endtask

   // a malfunction reset: entry, exact length, cause in status
   task automatic malf(input int b);
      int n;
      #1;
      n = 0;
      while (sys_reset_n === 1'b1 && n < 10) begin
         @(posedge aclk);
         #1;
         n++;
      end
      `CHK("reset entry", 1'b0, sys_reset_n)
      relwait(n);
      `CHK("reset length", rcs_pkg::MALF_CYCLES, n)
      `CHK("fast osc kept", 1'b1, hf_osc_enable)
      stat(b, 1'b1);
   endtask

   task automatic slow_edge;
      low_frequency_clock <= 1'b1;
      cyc(6);
      low_frequency_clock <= 1'b0;
      cyc(4);
   endtask

   task automatic fetch(input logic [15:0] a);
      fetch_valid <= 1'b1;
      fetch_addr <= a;
      @(posedge aclk);
      fetch_valid <= 1'b0;
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // watchdog against a hung run
   initial begin
      repeat (20000) @(posedge aclk);
      num_errors++;
      $display("[ERR] run time exp done got hang");
      final_report;
   end

   // main sequence
   initial begin
      int n, k;
      logic [31:0] d;
      logic [1:0] r;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      relwait(n);
      rd(rcs_pkg::OFF_SYSCTL, 32'h80);
      rd(rcs_pkg::OFF_TRAPCFG, 32'hf);
      rd(rcs_pkg::OFF_MASK, 32'h0);
      rd(rcs_pkg::OFF_MODE, 32'h0);
      axr(8'h14, d, r);
      `CHK("unmapped read", rcs_pkg::RESP_SLVERR, r)
      axw(8'h14, 32'h1, r);
      `CHK("unmapped write", rcs_pkg::RESP_SLVERR, r)
      $display("test reset values done");
      wr(rcs_pkg::OFF_SYSCTL, 32'hc0);
      `CHK("slow osc on", 1'b1, lf_osc_enable)
      wr(rcs_pkg::OFF_SYSCTL, 32'he0);
      rd(rcs_pkg::OFF_MODE, 32'h5);
      slow_edge;
      `CHK("on slow clock", 1'b1, main_clock_slow)
      wr(rcs_pkg::OFF_SYSCTL, 32'h60);
      `CHK("fast osc off", 1'b0, hf_osc_enable)
      `CHK("no clock reset", 1'b1, sys_reset_n)
      rd(rcs_pkg::OFF_MODE, 32'h3);
      stat(rcs_pkg::EV_SWITCH, 1'b1);
      wr(rcs_pkg::OFF_SYSCTL, 32'he0);
      wr(rcs_pkg::OFF_SYSCTL, 32'hc0);
      cyc(8);
      `CHK("still slow", 1'b1, main_clock_slow)
      rd(rcs_pkg::OFF_MODE, 32'h6);
      slow_edge;
      `CHK("back on fast", 1'b0, main_clock_slow)
      $display("test clock switch done");
      for (int i = 0; i < 3; i++) begin
         wr(rcs_pkg::OFF_SYSCTL, su[i]);
         axw(rcs_pkg::OFF_SYSCTL, fv[i], r);
         `CHK("fault resp", rcs_pkg::RESP_OKAY, r)
         malf(rcs_pkg::EV_CLK);
         rd(rcs_pkg::OFF_SYSCTL, 32'h80);
      end
      $display("test clock faults done");
      wdt_reset_req <= 1'b1;
      @(posedge aclk);
      wdt_reset_req <= 1'b0;
      malf(rcs_pkg::EV_WDT);
      $display("test watchdog done");
      for (int i = 0; i < 3; i++) begin
         fetch(ta[i]);
         malf(rcs_pkg::EV_TRAP_RST);
      end
      wr(rcs_pkg::OFF_TRAPCFG, 32'hc);
      k = trap_cnt;
      fetch(16'h0100);
      cyc(6);
      `CHK("ram not trapped", k, trap_cnt)
      fetch(16'h0f90);
      cyc(6);
      `CHK("trap interrupt", k + 1, trap_cnt)
      `CHK("trap no reset", 1'b1, sys_reset_n)
      fetch(16'h8000);
      cyc(6);
      `CHK("code not trapped", k + 1, trap_cnt)
      stat(rcs_pkg::EV_TRAP_IRQ, 1'b1);
      `CHK("irq masked", 1'b0, irq)
      wr(rcs_pkg::OFF_MASK, 32'h10);
      `CHK("irq unmasked", 1'b1, irq)
      wr(rcs_pkg::OFF_STATUS, 32'h10);
      `CHK("irq cleared", 1'b0, irq)
      stat(rcs_pkg::EV_TRAP_IRQ, 1'b0);
      $display("test address trap done");
      wr(rcs_pkg::OFF_SYSCTL, 32'hc0);
      wr(rcs_pkg::OFF_SYSCTL, 32'he0);
      slow_edge;
      `CHK("slow before pin", 1'b1, main_clock_slow)
      reset_pin_n <= 1'b0;
      cyc(10);
      reset_pin_n <= 1'b1;
      cyc(8);
      `CHK("short pin ignored", 1'b1, sys_reset_n)
      reset_pin_n <= 1'b0;
      cyc(25);
      `CHK("pin reset", 1'b0, sys_reset_n)
      `CHK("slow ended", 1'b0, main_clock_slow)
      reset_pin_n <= 1'b1;
      relwait(n);
      stat(rcs_pkg::EV_EXT, 1'b1);
      rd(rcs_pkg::OFF_SYSCTL, 32'h80);
      $display("test reset pin done");
      final_report;
   end
endmodule
